// file: rtl/serial_port_clock_and_signals.sv
// serial port modem signals, interrupt output and bit clock source
// assumes an APB master on pclk; tx/rx engines outside on pclk
//
// Summary of operation
// - assert and negate commands set request-to-send
// - active-low interrupt from unmasked status bits
// - acknowledge gives autovector or stored vector
// - full receive fifo with mask requests DMA
// - port zero to channel two, one three
// - transmit line idles high when not sending
// - transmit bits change on bit clock fall
// - receive bits sampled on bit clock rise
// - clear-to-send change can raise an interrupt
// - receiver or transmitter can drive request-to-send
// - bus clock over 32 then 16-bit divider
// - timer input undivided or divided by sixteen
// - clock select register picks the source
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module serial_port_clock_and_signals #(
  parameter bit PORT_INDEX = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_in,
  input wire logic cts_n,
  input wire logic rxd,
  output logic txd,
  output logic rts_n,
  input wire logic tx_bit,
  input wire logic tx_active,
  input wire logic tx_enable,
  input wire logic loopback,
  input wire logic tx_complete,
  input wire logic tx_ready,
  input wire logic rx_ready,
  input wire logic rx_fifo_full,
  input wire logic break_change,
  output logic tx_shift,
  output logic rx_sample,
  output logic rx_bit,
  input wire logic iack,
  output logic irq_n,
  output logic irq,
  output logic [7:0] ack_vector,
  output logic ack_vector_valid,
  output logic ack_autovector,
  output logic dma_req_ch2,
  output logic dma_req_ch3
);

  // ==========================================================
  // declarations
  logic [7:0] status;
  logic [7:0] mask;
  logic [7:0] vector;
  logic [15:0] divisor;
  logic [1:0] clk_select;
  logic [3:0] control;
  logic [1:0] timer_sync;
  logic [1:0] cts_sync;
  logic [1:0] rxd_sync;
  logic cts_prev;
  logic full_prev;
  logic wr;
  logic setup;
  logic [7:0] wbyte;
  logic [7:0] status_set;
  logic [7:0] status_clr;
  logic [7:0] next_status;
  logic [31:0] next_rdata;
  serial_port_pkg::rts_mode_t rts_mode;
  bit_clock_if bc();

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      serial_port_pkg::OFS_ASSERT_CMD,
      serial_port_pkg::OFS_NEGATE_CMD,
      serial_port_pkg::OFS_STATUS,
      serial_port_pkg::OFS_MASK,
      serial_port_pkg::OFS_VECTOR,
      serial_port_pkg::OFS_DIV_UPPER,
      serial_port_pkg::OFS_DIV_LOWER,
      serial_port_pkg::OFS_CLK_SELECT,
      serial_port_pkg::OFS_CONTROL,
      serial_port_pkg::OFS_INPUT_PORT,
      serial_port_pkg::OFS_STATUS_CLEAR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  function automatic logic wr_to(input logic w, input logic [7:0] a,
                                 input logic [7:0] ofs);
    wr_to = w && (a == ofs);
  endfunction

  // ==========================================================
  // apb slave: one wait-free access phase after setup
  assign setup = psel & ~penable;
  // writes to unmapped offsets are dropped and flagged
  assign wr = psel & penable & pready & pwrite & addr_ok(paddr);
  assign wbyte = pwdata[7:0];
  assign rts_mode = serial_port_pkg::rts_mode_t'(
    control[serial_port_pkg::CTL_MODE_HI:serial_port_pkg::CTL_MODE_LO]);

  always_comb begin
    next_rdata = '0;
    case (paddr)
      serial_port_pkg::OFS_STATUS: next_rdata[7:0] = status;
      serial_port_pkg::OFS_MASK: next_rdata[7:0] = mask;
      serial_port_pkg::OFS_VECTOR: next_rdata[7:0] = vector;
      serial_port_pkg::OFS_CLK_SELECT: next_rdata[1:0] = clk_select;
      serial_port_pkg::OFS_CONTROL: next_rdata[3:0] = control;
      serial_port_pkg::OFS_INPUT_PORT:
        next_rdata[serial_port_pkg::CTS_BIT] = cts_sync[1];
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addr_ok(paddr);
      prdata <= (setup && !pwrite) ? next_rdata : '0;
    end
  end

  // ==========================================================
  // configuration registers
  // divider halves write-only, read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor <= serial_port_pkg::DIVIDER_RESET;
    end else begin
      if (wr_to(wr, paddr, serial_port_pkg::OFS_DIV_UPPER)) begin
        divisor[15:8] <= wbyte;
      end
      if (wr_to(wr, paddr, serial_port_pkg::OFS_DIV_LOWER)) begin
        divisor[7:0] <= wbyte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
      vector <= serial_port_pkg::VECTOR_RESET;
      clk_select <= serial_port_pkg::CLK_SELECT_RESET;
      control <= serial_port_pkg::CONTROL_RESET;
    end else begin
      if (wr_to(wr, paddr, serial_port_pkg::OFS_MASK)) begin
        mask <= wbyte & serial_port_pkg::ISR_USED;
      end
      if (wr_to(wr, paddr, serial_port_pkg::OFS_VECTOR)) begin
        vector <= wbyte;
      end
      if (wr_to(wr, paddr, serial_port_pkg::OFS_CLK_SELECT)) begin
        clk_select <= wbyte[1:0];
      end
      if (wr_to(wr, paddr, serial_port_pkg::OFS_CONTROL)) begin
        control <= wbyte[3:0];
      end
    end
  end

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_sync <= '0;
      cts_sync <= 2'b11;
      rxd_sync <= 2'b11;
      cts_prev <= 1'b1;
      full_prev <= 1'b0;
    end else begin
      timer_sync <= {timer_sync[0], timer_in};
      cts_sync <= {cts_sync[0], cts_n};
      rxd_sync <= {rxd_sync[0], rxd};
      cts_prev <= cts_sync[1];
      full_prev <= rx_fifo_full;
    end
  end

  // ==========================================================
  // interrupt status, sticky until cleared; set beats clear
  always_comb begin
    status_set = '0;
    status_set[serial_port_pkg::ISR_COS] = (cts_sync[1] != cts_prev) &
      control[serial_port_pkg::CTL_COS_EN];
    status_set[serial_port_pkg::ISR_DB] = break_change;
    status_set[serial_port_pkg::ISR_RX] = rx_ready | rx_fifo_full;
    status_set[serial_port_pkg::ISR_TX] = tx_ready;
    status_clr = wr_to(wr, paddr, serial_port_pkg::OFS_STATUS_CLEAR) ?
      wbyte : 8'h00;
    next_status = (status & ~status_clr) | status_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      irq_n <= ~|(next_status & mask);
      irq <= |(next_status & mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_vector <= '0;
      ack_vector_valid <= 1'b0;
      ack_autovector <= 1'b0;
    end else begin
      ack_vector <= vector;
      ack_vector_valid <= iack & control[serial_port_pkg::CTL_VECTOR];
      ack_autovector <= iack & ~control[serial_port_pkg::CTL_VECTOR];
    end
  end

  // ==========================================================
  // dma requests; level while the fifo stays full
  // full fifo with mask asks dma
  // port zero on channel two, one on three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req_ch2 <= 1'b0;
      dma_req_ch3 <= 1'b0;
    end else begin
      dma_req_ch2 <= ~PORT_INDEX & mask[serial_port_pkg::ISR_RX] &
        rx_fifo_full;
      dma_req_ch3 <= PORT_INDEX & mask[serial_port_pkg::ISR_RX] &
        rx_fifo_full;
    end
  end

  // ==========================================================
  // request-to-send, kept low-active in its own flip-flop
  // held until the next command or auto action
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n <= 1'b1;
    end else begin
      // assert then negate; zero bits ignored
      if (wr_to(wr, paddr, serial_port_pkg::OFS_ASSERT_CMD) &&
          wbyte[serial_port_pkg::RTS_BIT]) begin
        rts_n <= 1'b0;
      end else if (wr_to(wr, paddr, serial_port_pkg::OFS_NEGATE_CMD) &&
                   wbyte[serial_port_pkg::RTS_BIT]) begin
        rts_n <= 1'b1;
      end else begin
        case (rts_mode)
          serial_port_pkg::RTS_BY_RX: begin
            if (rx_fifo_full && !full_prev) begin
              rts_n <= 1'b1;
            end else if (!rx_fifo_full && full_prev) begin
              rts_n <= 1'b0;
            end
          end
          serial_port_pkg::RTS_BY_TX: begin
            if (tx_complete) begin
              rts_n <= 1'b1;
            end
          end
          default: begin
            rts_n <= rts_n;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // bit clock generator
  // timer input assumed free of capture use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc.sel_ext <= 1'b0;
      bc.ext_div16 <= 1'b0;
      bc.divisor <= serial_port_pkg::DIVIDER_RESET;
      bc.ext_level <= 1'b0;
    end else begin
      bc.sel_ext <= clk_select[serial_port_pkg::CSR_EXT];
      bc.ext_div16 <= clk_select[serial_port_pkg::CSR_DIV16];
      bc.divisor <= divisor;
      bc.ext_level <= timer_sync[1];
    end
  end

  bit_clock_gen u_bit_clock_gen (
    .pclk(pclk),
    .presetn(presetn),
    .bc(bc.gen)
  );

  // ==========================================================
  // serial lines
  // transmit changes on falling edge
  // mark when disabled, idle or looped back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
      tx_shift <= 1'b0;
    end else begin
      tx_shift <= bc.bit_fall;
      if (!tx_enable || !tx_active || loopback) begin
        txd <= 1'b1;
      end else if (bc.bit_fall) begin
        txd <= tx_bit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bit <= 1'b1;
      rx_sample <= 1'b0;
    end else begin
      rx_sample <= bc.bit_rise;
      if (bc.bit_rise) begin
        rx_bit <= rxd_sync[1];
      end
    end
  end

endmodule // serial_port_clock_and_signals

// file: rtl/serial_port_pkg.sv
// constants shared by the serial port clock and signal block
// assumes a 32-bit APB with word-aligned registers
package serial_port_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_ASSERT_CMD = 8'h00;
  localparam logic [7:0] OFS_NEGATE_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_VECTOR = 8'h10;
  localparam logic [7:0] OFS_DIV_UPPER = 8'h14;
  localparam logic [7:0] OFS_DIV_LOWER = 8'h18;
  localparam logic [7:0] OFS_CLK_SELECT = 8'h1C;
  localparam logic [7:0] OFS_CONTROL = 8'h20;
  localparam logic [7:0] OFS_INPUT_PORT = 8'h24;
  localparam logic [7:0] OFS_STATUS_CLEAR = 8'h28;

  // ==========================================================
  // field positions
  localparam int RTS_BIT = 0;
  localparam int ISR_COS = 7;
  localparam int ISR_DB = 2;
  localparam int ISR_RX = 1;
  localparam int ISR_TX = 0;
  localparam logic [7:0] ISR_USED = 8'h87;
  localparam int CSR_EXT = 0;
  localparam int CSR_DIV16 = 1;
  localparam int CTL_COS_EN = 0;
  localparam int CTL_MODE_LO = 1;
  localparam int CTL_MODE_HI = 2;
  localparam int CTL_VECTOR = 3;
  localparam int CTS_BIT = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] VECTOR_RESET = 8'h0F;
  localparam logic [15:0] DIVIDER_RESET = 16'h0002;
  localparam logic [1:0] CLK_SELECT_RESET = 2'h0;
  localparam logic [3:0] CONTROL_RESET = 4'h0;

  // ==========================================================
  // clock generator figures
  localparam int PRESCALE = 32;
  localparam int EXT_DIVIDE = 16;

  typedef enum logic [1:0] {
    RTS_MANUAL = 2'b00,
    RTS_BY_RX = 2'b01,
    RTS_BY_TX = 2'b10
  } rts_mode_t;

endpackage

// file: rtl/bit_clock_if.sv
// signals between the register block and the bit clock generator
// assumes both ends run on the same bus clock
`timescale 1ns/1ps
interface bit_clock_if;
  logic sel_ext;
  logic ext_div16;
  logic [15:0] divisor;
  logic ext_level;
  logic bit_rise;
  logic bit_fall;

  modport gen (
    input sel_ext,
    input ext_div16,
    input divisor,
    input ext_level,
    output bit_rise,
    output bit_fall
  );
  modport user (
    output sel_ext,
    output ext_div16,
    output divisor,
    output ext_level,
    input bit_rise,
    input bit_fall
  );
endinterface

// file: rtl/bit_clock_gen.sv
// bit clock generator: edge pulses of the selected bit clock
// assumes ext_level is already synchronised to pclk
`timescale 1ns/1ps
module bit_clock_gen #(
  parameter int PRESCALE = serial_port_pkg::PRESCALE,
  parameter int EXT_DIVIDE = serial_port_pkg::EXT_DIVIDE
) (
  input wire logic pclk,
  input wire logic presetn,
  bit_clock_if.gen bc
);
  localparam int PW = $clog2(PRESCALE);
  localparam int EW = $clog2(EXT_DIVIDE);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
  localparam logic [EW-1:0] EXT_HALF = EW'(EXT_DIVIDE / 2);

  logic [PW-1:0] pre_cnt;
  logic [15:0] div_cnt;
  logic [EW-1:0] ext_cnt;
  logic ext_prev;
  logic pre_tick;
  logic ext_up;
  logic ext_down;
  logic next_rise;
  logic next_fall;

  assign pre_tick = (pre_cnt == PRE_LAST);
  assign ext_up = bc.ext_level & ~ext_prev;
  assign ext_down = ~bc.ext_level & ext_prev;

  // ==========================================================
  // bus clock path
  // fixed prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_tick ? '0 : pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (pre_tick) begin
      div_cnt <= (div_cnt >= bc.divisor - 16'h0001) ? '0 : div_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // external timer input path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
      ext_cnt <= '0;
    end else begin
      ext_prev <= bc.ext_level;
      if (ext_up) begin
        ext_cnt <= ext_cnt + 1'b1;
      end
    end
  end

  always_comb begin
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (!bc.sel_ext) begin
      next_rise = pre_tick && (div_cnt == '0);
      next_fall = pre_tick && (div_cnt == (bc.divisor >> 1));
    end else if (!bc.ext_div16) begin
      next_rise = ext_up;
      next_fall = ext_down;
    end else begin
      next_rise = ext_up && (ext_cnt == '0);
      next_fall = ext_up && (ext_cnt == EXT_HALF);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc.bit_rise <= 1'b0;
      bc.bit_fall <= 1'b0;
    end else begin
      bc.bit_rise <= next_rise;
      bc.bit_fall <= next_fall;
    end
  end

endmodule // bit_clock_gen

// file: bench/serial_port_properties.sv
// checker for the serial port block, sees its top-level ports only
// assumes one pclk domain with asynchronous active-low presetn
`timescale 1ns/1ps
module serial_port_checker #(
  parameter bit PORT_INDEX = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic tx_active,
  input wire logic tx_enable,
  input wire logic loopback,
  input wire logic rx_fifo_full,
  input wire logic rx_sample,
  input wire logic rx_bit,
  input wire logic iack,
  input wire logic irq_n,
  input wire logic irq,
  input wire logic ack_vector_valid,
  input wire logic ack_autovector,
  input wire logic dma_req_ch2,
  input wire logic dma_req_ch3
);
  // ==========================================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  assign wr_acc = psel && penable && pready && pwrite;
  rts_on_cmd_a: assert property (wr_acc && pwdata[0] &&
    paddr == serial_port_pkg::OFS_ASSERT_CMD |-> ##[1:2] !rts_n)
    else $error("rts not asserted");
  rts_off_cmd_a: assert property (wr_acc && pwdata[0] &&
    paddr == serial_port_pkg::OFS_NEGATE_CMD |-> ##[1:2] rts_n)
    else $error("rts not negated");
  irq_pair_a: assert property (irq == !irq_n)
    else $error("irq pair split");
  ack_kind_a: assert property (
    iack |=> ack_vector_valid != ack_autovector)
    else $error("bad ack");
  dma_cause_a: assert property (
    dma_req_ch2 || dma_req_ch3 |-> $past(rx_fifo_full))
    else $error("dma no cause");
  dma_route_a: assert property (
    PORT_INDEX ? !dma_req_ch2 : !dma_req_ch3)
    else $error("dma wrong channel");
  txd_mark_a: assert property (
    !tx_enable || !tx_active || loopback |=> txd)
    else $error("txd not mark");
  rx_bit_hold_a: assert property ($changed(rx_bit) |-> rx_sample)
    else $error("rx_bit moved");
  sample_once_a: assert property (rx_sample |=> !rx_sample)
    else $error("long sample pulse");
  cover property (iack ##1 ack_vector_valid);
  cover property (dma_req_ch2);
  cover property (!irq_n ##1 irq_n);
endmodule // serial_port_checker

bind serial_port_clock_and_signals serial_port_checker
  #(.PORT_INDEX(PORT_INDEX)) u_serial_port_checker (.*);

// file: bench/serial_partner.sv
// remote serial device: sends framed bits with a clock it makes
// assumes that clock is wired to the block's timer input
`timescale 1ns/1ps
module serial_partner #(
  parameter int HALF = 8
) (
  input wire logic pclk,
  input wire logic send,
  input wire logic [39:0] word,
  input wire logic [5:0] nclk,
  input wire logic cts_hold,
  input wire logic rts_n,
  output logic timer_in,
  output logic rxd,
  output logic cts_n,
  output logic busy
);
  // ==========================================================
  // line behaviour
  assign cts_n = cts_hold;
  // clock stands still between frames, line rests at mark
  // timer pin only clocks port
  initial begin
    timer_in = 1'b0;
    rxd = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      // only starts a frame while the block grants the line
      if (send && !rts_n) begin
        busy <= 1'b1;
        for (int i = 0; i < nclk; i++) begin
          rxd <= word[i];
          repeat (HALF) @(posedge pclk);
          timer_in <= 1'b1;
          repeat (HALF) @(posedge pclk);
          timer_in <= 1'b0;
        end
        rxd <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule // serial_partner

// file: bench/serial_port_clock_and_signals_tb_top.sv
// testbench for the serial port clock and signal block
// assumes the partner model and checker are compiled beforehand
`timescale 1ns/1ps
module serial_port_clock_and_signals_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, rts_n;
  logic [7:0] paddr, ack_vector, v, d;
  logic [31:0] pwdata, prdata, r;
  logic timer_in, cts_n, rxd, tx_bit, tx_active, tx_enable, loopback;
  logic tx_complete, tx_ready, rx_ready, rx_fifo_full, break_change;
  logic tx_shift, rx_sample, rx_bit, iack, irq_n, irq, ack_vector_valid;
  logic ack_autovector, dma_req_ch2, dma_req_ch3, send, busy, cts_hold;
  logic [39:0] word, rxw;
  logic [5:0] nclk;
  logic [32:0] expq[$];
  int n_fail = 0, num_checks = 0, seed = 90929, nrx, ntx, n;

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  serial_port_clock_and_signals #(.PORT_INDEX(1'b0))
    u_serial_port_clock_and_signals (.*);
  serial_partner u_serial_partner (.*);

  // ==========================================================
  // shared tasks
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pin(input logic s, input logic e);
    check({32'h0, s}, {32'h0, e});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, input logic [32:0] e);
    if (!w) expq.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    apb(1'b1, a, {24'h0, wd}, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, {25'h0, e});
  endtask
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic period(input int e);
    repeat (2) @(posedge pclk iff rx_sample === 1'b1);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rx_sample !== 1'b1);
    check(33'(n), 33'(e));
  endtask
  task automatic frame(input logic [39:0] wd, input logic [5:0] nc);
    nrx = 0;
    ntx = 0;
    word <= wd;
    nclk <= nc;
    send <= 1'b1;
    @(posedge pclk iff busy === 1'b1);
    send <= 1'b0;
    @(posedge pclk iff busy === 1'b0);
    repeat (8) @(posedge pclk);
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // output watcher: read data against noted values, serial counts
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check({pslverr, prdata}, expq.pop_front());
    end
    if (rx_sample === 1'b1) begin
      rxw <= {rx_bit, rxw[39:1]};
      nrx <= nrx + 1;
    end
    if (tx_shift === 1'b1) ntx <= ntx + 1;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude;
  end

  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, iack, send} = '0;
    {tx_bit, tx_active, tx_enable, loopback, tx_complete} = '0;
    {tx_ready, rx_ready, rx_fifo_full, break_change, cts_hold} = '0;
    {word, nclk, rxw} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(serial_port_pkg::OFS_VECTOR, serial_port_pkg::VECTOR_RESET);
    rd(serial_port_pkg::OFS_ASSERT_CMD, 8'h00);
    rd(serial_port_pkg::OFS_DIV_LOWER, 8'h00);
    rd(serial_port_pkg::OFS_INPUT_PORT, 8'h00);
    apb(1'b0, 8'h2C, 32'h0, {1'b1, 32'h0});
    r = $random(seed);
    v = r[7:0];
    apb(1'b1, serial_port_pkg::OFS_VECTOR, r, 33'h0);
    rd(serial_port_pkg::OFS_VECTOR, v);
    wr(serial_port_pkg::OFS_ASSERT_CMD, 8'h01);
    settle;
    pin(rts_n, 1'b0);
    wr(serial_port_pkg::OFS_NEGATE_CMD, 8'h00);
    settle;
    pin(rts_n, 1'b0);
    wr(serial_port_pkg::OFS_NEGATE_CMD, 8'h01);
    settle;
    pin(rts_n, 1'b1);
    wr(serial_port_pkg::OFS_MASK, 8'h87);
    wr(serial_port_pkg::OFS_CONTROL, 8'h01);
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      {cts_hold, break_change, rx_ready, tx_ready} <= 4'(1 << k);
      settle;
      @(posedge pclk);
      {cts_hold, break_change, rx_ready, tx_ready} <= 4'h0;
      settle;
      d = (k == 3) ? 8'h80 : 8'(1 << k);
      pin(irq_n, 1'b0);
      pin(irq, 1'b1);
      rd(serial_port_pkg::OFS_STATUS, d);
      wr(serial_port_pkg::OFS_STATUS_CLEAR, d);
      settle;
      pin(irq_n, 1'b1);
      pin(irq, 1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      wr(serial_port_pkg::OFS_CONTROL, k ? 8'h08 : 8'h00);
      iack <= 1'b1;
      @(posedge pclk);
      iack <= 1'b0;
      #1;
      pin(ack_vector_valid, k[0]);
      pin(ack_autovector, !k[0]);
    end
    check({25'h0, ack_vector}, {25'h0, v});
    wr(serial_port_pkg::OFS_MASK, 8'h02);
    wr(serial_port_pkg::OFS_CONTROL, 8'h02);
    wr(serial_port_pkg::OFS_ASSERT_CMD, 8'h01);
    rx_fifo_full <= 1'b1;
    settle;
    pin(dma_req_ch2, 1'b1);
    pin(dma_req_ch3, 1'b0);
    pin(rts_n, 1'b1);
    @(posedge pclk);
    rx_fifo_full <= 1'b0;
    settle;
    pin(rts_n, 1'b0);
    wr(serial_port_pkg::OFS_STATUS_CLEAR, 8'h02);
    wr(serial_port_pkg::OFS_CONTROL, 8'h04);
    tx_complete <= 1'b1;
    @(posedge pclk);
    tx_complete <= 1'b0;
    settle;
    pin(rts_n, 1'b1);
    wr(serial_port_pkg::OFS_CONTROL, 8'h00);
    wr(serial_port_pkg::OFS_ASSERT_CMD, 8'h01);
    wr(serial_port_pkg::OFS_DIV_UPPER, 8'h00);
    for (int k = 2; k < 4; k++) begin
      wr(serial_port_pkg::OFS_DIV_LOWER, 8'(k));
      period(serial_port_pkg::PRESCALE * k);
    end
    wr(serial_port_pkg::OFS_CLK_SELECT, 8'h01);
    d = 8'($random(seed));
    tx_bit <= d[0];
    tx_enable <= 1'b1;
    tx_active <= 1'b1;
    frame({30'h0, 1'b1, d, 1'b0}, 6'd10);
    check({23'h0, rxw[39:30]}, {23'h0, 1'b1, d, 1'b0});
    check(33'(nrx), 33'd10);
    check(33'(ntx), 33'd10);
    pin(txd, d[0]);
    loopback <= 1'b1;
    settle;
    pin(txd, 1'b1);
    wr(serial_port_pkg::OFS_CLK_SELECT, 8'h03);
    frame({$random(seed), 8'h00}, 6'd32);
    check(33'(nrx), 33'd2);
    conclude;
  end
endmodule // serial_port_clock_and_signals_tb_top
